// [dv/tb_top.sv]
// Self-checking bench for the signal decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STALL = 5;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  upmsd_pkg::upmsd_word_t word_i = '0;
  logic [1:0] div = 2'h1;
  logic dflt = 1'b0, sel = 1'b0, rd = 1'b0, arm = 1'b0;
  logic word_ready_o, word_done_o, sample_data_o, waiting_o, mem_wait;
  upmsd_pkg::upmsd_pins_t pins_o;
  int err_total = 0, comparisons = 0, cycles = 0, n;
  logic [31:0] tbl [4] = '{32'h5F0A_5C00, 32'hAFB5_A800, 32'h3FE6_9400, 32'hC0F3_6000};
  upmsd_decoder dut (.mclk_i, .srst_i, .ce_i(1'b1), .word_i, .word_ready_o, .word_done_o,
    .bus_clock_divider_i(div), .line0_default_level_i(dflt), .line4_direction_select_i(sel),
    .read_access_i(rd), .memory_wait_input_i(mem_wait), .pins_o, .sample_data_o, .waiting_o);
  upmsd_mem_model #(.STALL(STALL)) mem (.mclk_i, .srst_i, .arm_i(arm), .pins_i(pins_o), .wait_o(mem_wait));
  always #50 mclk_i = ~mclk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic send(input logic [31:0] w);
    int k;
    k = 0;
    word_i = {1'b1, w};
    while (word_ready_o !== 1'b1 && k < 50) begin
      step();
      k++;
    end
    step();
    word_i.valid = 1'b0;
  endtask
  // Length counts the first shown cycle up to the finishing one
  task automatic run_len(input logic [31:0] w, output int len);
    send(w);
    len = 1;
    while (word_done_o !== 1'b1 && len < 100) begin
      step();
      len++;
    end
  endtask
  function automatic logic lvl(input logic [1:0] c);
    return c == 2'h0 ? dflt : c[0];
  endfunction
  function automatic logic [7:0] exp_pins(input logic [31:0] w, input int q);
    return {w[31 - q], q >= 2 ? {w[10], w[12], w[14], w[16], w[18], lvl(w[21:20])}
      : {w[11], w[13], w[15], w[17], w[19], lvl(w[23:22])}, 1'b0};
  endfunction
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    #1;
    srst_i = 1'b0;
    // Back to back words, both default levels
    for (int i = 0; i < 8; i++) begin
      dflt = i[2];
      send(tbl[i % 4]);
      for (int q = 0; q < 4; q++) begin
        check(pins_o, exp_pins(tbl[i % 4], q));
        if (q < 3) step();
      end
    end
    send(32'h0090_0000);
    step();
    step();
    check(8'(pins_o.lines[0]), 8'h0);
    $display("field test done");
    repeat (2) step();
    div = 2'h0;
    send(32'h9000_0100);
    for (int q = 0; q < 4; q++) begin
      check(8'(pins_o.cs_n), 8'(!q[0]));
      check(8'(word_done_o), 8'(q == 3));
      step();
    end
    run_len(32'h0000_0300, n);
    check(8'(n), 8'h8);
    step();
    div = 2'h1;
    for (int r = 0; r < 4; r++) begin
      run_len({22'h0, r[1:0], 8'h00}, n);
      check(8'(n), 8'((r + 1) * 4));
      step();
    end
    div = 2'h2;
    run_len(32'h1000_0000, n);
    check(8'(n), 8'h8);
    check(8'(pins_o.cs_n), 8'h1);
    step();
    div = 2'h1;
    $display("repeat test done");
    sel = 1'b1;
    rd = 1'b1;
    send(32'hF000_2000);
    check(8'(sample_data_o), 8'h0);
    step();
    step();
    check(8'(sample_data_o), 8'h1);
    check(8'(pins_o.line4_oe_n), 8'h1);
    repeat (3) step();
    send(32'h0000_0000);
    repeat (3) step();
    check(8'(sample_data_o), 8'h0);
    step();
    check(8'(sample_data_o), 8'h1);
    $display("sample test done");
    arm = 1'b1;
    run_len(32'h0000_0100, n);
    check(8'(n), 8'h8);
    arm = 1'b0;
    step();
    arm = 1'b1;
    run_len(32'h0000_1100, n);
    check(8'(n), 8'(8 + STALL));
    $display("wait test done");
    finish_test();
  end
endmodule
bind upmsd_decoder upmsd_chk chk (.mclk_i, .srst_i, .word_i, .word_ready_o, .word_done_o, .bus_clock_divider_i,
  .line4_direction_select_i, .read_access_i, .pins_o, .sample_data_o, .waiting_o);

// [dv/upmsd_decoder_assertions.sv]
// Port assertions for the signal decoder
module upmsd_chk (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire upmsd_pkg::upmsd_word_t word_i,
  input wire logic word_ready_o,
  input wire logic word_done_o,
  input wire logic [1:0] bus_clock_divider_i,
  input wire logic line4_direction_select_i,
  input wire logic read_access_i,
  input wire upmsd_pkg::upmsd_pins_t pins_o,
  input wire logic sample_data_o,
  input wire logic waiting_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] held;
  logic take;
  logic div4;
  logic sel;
  assign take = word_ready_o && word_i.valid && !waiting_o;
  assign div4 = bus_clock_divider_i == 2'h1;
  assign sel = line4_direction_select_i;
  always_ff @(posedge mclk_i) begin
    if (take) begin
      held <= word_i.word;
    end
  end
  sequence cs_walk;
    pins_o.cs_n == held[31] ##1 pins_o.cs_n == held[30] ##1
    pins_o.cs_n == held[29] ##1 pins_o.cs_n == held[28];
  endsequence
  sequence cs_halves;
    pins_o.cs_n == held[31] ##1 pins_o.cs_n == held[29];
  endsequence
  cs_quarter_walk_a: assert property (take && div4 && !sel |=> cs_walk)
    else $error("chip select quarter levels wrong");
  cs_half_walk_a: assert property (take && bus_clock_divider_i == 2'h0 && !sel |=> cs_halves)
    else $error("chip select half levels wrong");
  lines_first_a: assert property (take |=> pins_o.lines[5] == held[11] && pins_o.lines[3] == held[15] &&
    pins_o.lines[2] == held[17] && pins_o.lines[1] == held[19]) else $error("general lines wrong in first quarter");
  line0_drive_a: assert property (take && word_i.word[23] |=> pins_o.lines[0] == held[22])
    else $error("line 0 forced level wrong");
  line4_out_a: assert property (take && !sel |=> !pins_o.line4_oe_n && pins_o.lines[4] == held[13])
    else $error("line 4 output wrong");
  line4_in_a: assert property (sel && $past(sel) |-> pins_o.line4_oe_n)
    else $error("shared pin driven in wait mode");
  sample_q3_a: assert property (take && div4 && sel && read_access_i && word_i.word[13] && !word_i.word[12]
    |-> ##3 sample_data_o) else $error("no sample strobe at quarter 3");
  sample_late_a: assert property (take && div4 && sel && read_access_i && !word_i.word[13] && !word_i.word[12]
    |-> ##5 sample_data_o) else $error("no sample strobe at next quarter 1");
  wait_freeze_a: assert property (waiting_o |=> $stable({pins_o.cs_n, pins_o.lines[5], pins_o.lines[3:0]}))
    else $error("pins moved during wait");
  wait_cause_a: assert property (waiting_o |-> sel && held[12])
    else $error("wait freeze without enable");
  redo_len_a: assert property (take && bus_clock_divider_i == 2'h0 && word_i.word[9:8] == 2'h3 && !sel
    |=> !word_done_o [*7] ##1 word_done_o) else $error("four-fold word length wrong");
endmodule

// [dv/upmsd_mem_model.sv]
// Memory device model that stretches an access with its wait line
module upmsd_mem_model #(
  parameter int STALL = 5
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic arm_i,
  input wire upmsd_pkg::upmsd_pins_t pins_i,
  output logic wait_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic used;
  // One stall per arming, so a long access cannot hang the run
  always_ff @(posedge mclk_i) begin
    if (srst_i || !arm_i) begin
      cnt <= 4'h0;
      used <= 1'b0;
    end else if (!used && !pins_i.cs_n) begin
      cnt <= 4'(STALL);
      used <= 1'b1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign wait_o = cnt != 4'h0;
endmodule

// [rtl/upmsd_cfg.svh]
// Field positions, codes and widths for the micro-instruction signal decoder
`ifndef UPMSD_CFG_SVH
`define UPMSD_CFG_SVH
`define UPMSD_CS_PH1 31
`define UPMSD_CS_PH2 30
`define UPMSD_CS_PH3 29
`define UPMSD_CS_PH4 28
`define UPMSD_L0_FIRST_HI 23
`define UPMSD_L0_FIRST_LO 22
`define UPMSD_L0_SECOND_HI 21
`define UPMSD_L0_SECOND_LO 20
`define UPMSD_L1_FIRST 19
`define UPMSD_L1_SECOND 18
`define UPMSD_L2_FIRST 17
`define UPMSD_L2_SECOND 16
`define UPMSD_L3_FIRST 15
`define UPMSD_L3_SECOND 14
`define UPMSD_L4_FIRST_OR_SAMPLE 13
`define UPMSD_L4_SECOND_OR_WAIT 12
`define UPMSD_L5_FIRST 11
`define UPMSD_L5_SECOND 10
`define UPMSD_REDO_HI 9
`define UPMSD_REDO_LO 8
`define UPMSD_LINE_DEFAULT 2'h0
`define UPMSD_LINE_RESERVED 2'h1
`define UPMSD_LINE_LOW 2'h2
`define UPMSD_LINE_HIGH 2'h3
`define UPMSD_DIV_2 2'h0
`define UPMSD_DIV_4 2'h1
`define UPMSD_DIV_8 2'h2
`define UPMSD_PHASE_LAST 2'h3
`define UPMSD_PRE_ZERO 3'h0
`define UPMSD_CS_IDLE 1'h1
`endif

// [rtl/upmsd_decoder.sv]
// Micro-instruction upper-field decoder and signal timing generator
//
// Contract
// RULE_01 - Bit 31 sets chip select in quarter 1, or first half at divider 2.
// RULE_02 - Bit 30 sets chip select in quarter 2; ignored at divider 2.
// RULE_03 - Bit 29 sets chip select in quarter 3, or second half at divider 2.
// RULE_04 - Bit 28 sets chip select in quarter 4; ignored at divider 2.
// RULE_05 - Bits 23-22 set line 0 first half: default, reserved, low, high.
// RULE_06 - Bits 21-20 set line 0 second half with the same coding.
// RULE_07 - Bits 19 and 18 set line 1 in first and second halves.
// RULE_08 - Bits 17 and 16 set line 2 in first and second halves.
// RULE_09 - Bits 15 and 14 set line 3 in first and second halves.
// RULE_10 - Bits 11 and 10 set line 5 in first and second halves.
// RULE_11 - Select bit 0: shared pin is output line 4, bit 13 first half.
// RULE_12 - Select bit 0: bit 12 sets line 4 in second half.
// RULE_13 - Select bit 1, reads: bit 13 picks sample at next quarter 1 or quarter 3.
// RULE_14 - Select bit 1: bit 12 enables wait; asserted wait freezes all pins.
// RULE_15 - Bits 9-8 execute the word one to four times.
// RULE_16 - At divider 2 quarter changes become half-cycle changes.
// RULE_17 - Bits 27-24 ignored; reserved line 0 code holds line level.
`include "upmsd_cfg.svh"
module upmsd_decoder (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire upmsd_pkg::upmsd_word_t word_i,
  output logic word_ready_o,
  output logic word_done_o,
  input wire logic [1:0] bus_clock_divider_i,
  input wire logic line0_default_level_i,
  input wire logic line4_direction_select_i,
  input wire logic read_access_i,
  input wire logic memory_wait_input_i,
  output upmsd_pkg::upmsd_pins_t pins_o,
  output logic sample_data_o,
  output logic waiting_o
);
  logic [31:0] word;
  logic active;
  logic [1:0] redo_left;
  logic wait_meta;
  logic wait_sync;
  logic tick;
  logic frozen;
  logic div2;
  logic last_phase;
  logic pin_cs_n;
  logic [5:0] pin_lines;
  logic pin_oe_n;
  logic next_cs_n;
  logic [5:0] next_lines;
  upmsd_pkg::upmsd_phase_t phase;
  upmsd_pkg::upmsd_phase_t shown_phase;

  // Wait pin crosses in from the memory side
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_meta <= 1'h0;
      wait_sync <= 1'h0;
    end else if (ce_i) begin
      wait_meta <= memory_wait_input_i;
      wait_sync <= wait_meta;
    end
  end

  assign div2 = (bus_clock_divider_i == `UPMSD_DIV_2);
  // Wait freeze only counts while the pin is an input and the word enables it
  assign frozen = active && line4_direction_select_i && word[`UPMSD_L4_SECOND_OR_WAIT] && wait_sync; // [RULE_14]
  assign waiting_o = frozen;

  upmsd_phase_gen #(
    .PRE_W(3)
  ) u_phase (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i && !frozen), // [RULE_14]
    .run_i(active),
    .div_i(bus_clock_divider_i),
    .tick_o(tick),
    .phase_o(phase)
  );

  assign last_phase = div2 ? (phase == upmsd_pkg::UPMSD_Q3) : (phase == upmsd_pkg::UPMSD_Q4);
  assign word_ready_o = !active || (tick && last_phase && redo_left == 2'h0 && !frozen);
  assign word_done_o = active && tick && last_phase && redo_left == 2'h0 && !frozen;

  // Word register and repeat counter
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      word <= 32'h0000_0000;
      active <= 1'h0;
      redo_left <= 2'h0;
    end else if (ce_i && !frozen) begin
      if (word_ready_o) begin
        active <= word_i.valid;
        if (word_i.valid) begin
          word <= word_i.word;
          redo_left <= word_i.word[`UPMSD_REDO_HI:`UPMSD_REDO_LO]; // [RULE_15]
        end
      end else if (tick && last_phase) begin
        redo_left <= redo_left - 2'h1; // [RULE_15]
      end
    end
  end

  // Phase whose levels should be on the pins next; divider 2 only visits Q1 and Q3
  always_comb begin
    shown_phase = phase;
    if (word_ready_o && word_i.valid) begin
      shown_phase = upmsd_pkg::UPMSD_Q1;
    end else if (tick) begin
      shown_phase = upmsd_pkg::upmsd_phase_t'(2'(phase) + (div2 ? 2'h2 : 2'h1)); // [RULE_16]
    end
  end

  function automatic logic line0_level(input logic [1:0] code, input logic dflt, input logic hold);
    logic lvl;
    lvl = hold;
    unique case (code)
      `UPMSD_LINE_DEFAULT: lvl = dflt;
      `UPMSD_LINE_RESERVED: lvl = hold; // [RULE_17]
      `UPMSD_LINE_LOW: lvl = 1'h0;
      `UPMSD_LINE_HIGH: lvl = 1'h1;
    endcase
    return lvl;
  endfunction

  logic [31:0] src;
  logic first_half;
  assign src = (word_ready_o && word_i.valid) ? word_i.word : word;
  assign first_half = (shown_phase == upmsd_pkg::UPMSD_Q1) || (shown_phase == upmsd_pkg::UPMSD_Q2);

  always_comb begin
    next_cs_n = pin_cs_n;
    next_lines = pin_lines;
    // A finished word with nothing behind it keeps its last levels
    if ((active && !word_done_o) || (word_ready_o && word_i.valid)) begin
      unique case (shown_phase)
        upmsd_pkg::UPMSD_Q1: next_cs_n = src[`UPMSD_CS_PH1]; // [RULE_01]
        upmsd_pkg::UPMSD_Q2: next_cs_n = src[`UPMSD_CS_PH2]; // [RULE_02]
        upmsd_pkg::UPMSD_Q3: next_cs_n = src[`UPMSD_CS_PH3]; // [RULE_03]
        upmsd_pkg::UPMSD_Q4: next_cs_n = src[`UPMSD_CS_PH4]; // [RULE_04]
      endcase
      if (first_half) begin
        next_lines[0] = line0_level(src[`UPMSD_L0_FIRST_HI:`UPMSD_L0_FIRST_LO],
                                    line0_default_level_i, pin_lines[0]); // [RULE_05]
        next_lines[1] = src[`UPMSD_L1_FIRST]; // [RULE_07]
        next_lines[2] = src[`UPMSD_L2_FIRST]; // [RULE_08]
        next_lines[3] = src[`UPMSD_L3_FIRST]; // [RULE_09]
        next_lines[5] = src[`UPMSD_L5_FIRST]; // [RULE_10]
        if (!line4_direction_select_i) begin
          next_lines[4] = src[`UPMSD_L4_FIRST_OR_SAMPLE]; // [RULE_11]
        end
      end else begin
        next_lines[0] = line0_level(src[`UPMSD_L0_SECOND_HI:`UPMSD_L0_SECOND_LO],
                                    line0_default_level_i, pin_lines[0]); // [RULE_06]
        next_lines[1] = src[`UPMSD_L1_SECOND]; // [RULE_07]
        next_lines[2] = src[`UPMSD_L2_SECOND]; // [RULE_08]
        next_lines[3] = src[`UPMSD_L3_SECOND]; // [RULE_09]
        next_lines[5] = src[`UPMSD_L5_SECOND]; // [RULE_10]
        if (!line4_direction_select_i) begin
          next_lines[4] = src[`UPMSD_L4_SECOND_OR_WAIT]; // [RULE_12]
        end
      end
    end
  end

  // Pins hold their last level between words, so a stall leaves no glitch
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_cs_n <= `UPMSD_CS_IDLE;
      pin_lines <= 6'h00;
    end else if (ce_i && !frozen) begin // [RULE_14]
      pin_cs_n <= next_cs_n;
      pin_lines <= next_lines;
    end
  end

  // Shared pin released on the clock edge after it is selected as the wait input
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_oe_n <= 1'h1;
    end else if (ce_i) begin
      pin_oe_n <= line4_direction_select_i; // [RULE_11]
    end
  end

  assign pins_o = {pin_cs_n, pin_lines, pin_oe_n};

  // Data sampling strobe: Q3 of this cycle, or Q1 of the next one
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sample_data_o <= 1'h0;
    end else if (ce_i) begin
      sample_data_o <= 1'h0;
      if (!frozen && tick && active && line4_direction_select_i && read_access_i) begin
        if (word[`UPMSD_L4_FIRST_OR_SAMPLE] && shown_phase == upmsd_pkg::UPMSD_Q3) begin
          sample_data_o <= 1'h1; // [RULE_13]
        end
        // Late sample lands on the edge that opens the next bus cycle
        if (!word[`UPMSD_L4_FIRST_OR_SAMPLE] && last_phase) begin
          sample_data_o <= 1'h1; // [RULE_13]
        end
      end
    end
  end
endmodule

// [rtl/upmsd_phase_gen.sv]
// Quarter-phase generator: divides the system clock into bus-clock quarters
`include "upmsd_cfg.svh"
module upmsd_phase_gen #(
  parameter int PRE_W = 3
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [1:0] div_i,
  output logic tick_o,
  output upmsd_pkg::upmsd_phase_t phase_o
);
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] pre_max;
  logic [1:0] step;

  // One bus quarter lasts div/4 system cycles; divider 2 walks by half phases
  always_comb begin
    pre_max = PRE_W'(0);
    step = 2'h1;
    unique case (div_i)
      `UPMSD_DIV_2: step = 2'h2;
      `UPMSD_DIV_4: pre_max = PRE_W'(0);
      `UPMSD_DIV_8: pre_max = PRE_W'(1);
      default: pre_max = PRE_W'(0);
    endcase
  end

  assign tick_o = run_i && (pre == pre_max);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pre <= PRE_W'(0);
    end else if (ce_i) begin
      if (!run_i || pre == pre_max) begin
        pre <= PRE_W'(0);
      end else begin
        pre <= pre + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      phase_o <= upmsd_pkg::UPMSD_Q1;
    end else if (ce_i) begin
      if (!run_i) begin
        phase_o <= upmsd_pkg::UPMSD_Q1;
      end else if (tick_o) begin
        phase_o <= upmsd_pkg::upmsd_phase_t'(2'(phase_o) + step); // [RULE_16]
      end
    end
  end
endmodule

// [rtl/upmsd_pkg.sv]
// Types shared by the micro-instruction signal decoder
package upmsd_pkg;
  typedef enum logic [1:0] {
    UPMSD_Q1,
    UPMSD_Q2,
    UPMSD_Q3,
    UPMSD_Q4
  } upmsd_phase_t;

  typedef struct packed {
    logic cs_n;
    logic [5:0] lines;
    logic line4_oe_n;
  } upmsd_pins_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } upmsd_word_t;
endpackage
